/* tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   localparam logic [15:0] DEFS [7] = '{tra_pkg::RST_SENSOR_SEL, tra_pkg::RST_CONV_TIME,
      tra_pkg::RST_NTC_B, tra_pkg::RST_NTC_RNOM, tra_pkg::RST_NTC_TREF,
      tra_pkg::RST_NTC_LOW, tra_pkg::RST_NTC_HIGH};
   logic        clk, rst_n, req, wr, nv_valid, busy, done, ok, nv_we, unlocked;
   logic [5:0]  num, nv_num;
   logic [2:0]  ch, nv_ch;
   logic [15:0] wdata, rdata, nv_data, act_conv, got;
   logic [7:0]  ntc_act;
   logic [15:0] nv_img [7][8];
   int          n_mismatch, cmp_count, nv_cnt;
   tra_if lnk ();
   tra_terminal tra_terminal_i (.I_CLK(clk), .I_RESETN(rst_n), .LNK(lnk),
      .I_NV_SENSOR(nv_img[0]), .I_NV_CONV(nv_img[1][0]), .I_NV_B(nv_img[2]),
      .I_NV_RNOM(nv_img[3]), .I_NV_TREF(nv_img[4]), .I_NV_LOW(nv_img[5]),
      .I_NV_HIGH(nv_img[6]), .I_NV_VALID(nv_valid), .O_NV_WE(nv_we), .O_NV_CH(nv_ch),
      .O_NV_NUM(nv_num), .O_NV_DATA(nv_data), .O_ACT_CONV(act_conv),
      .O_USER_NTC_ACTIVE(ntc_act), .O_UNLOCKED(unlocked));
   tra_master tra_master_i (.I_CLK(clk), .I_RESETN(rst_n), .I_REQ(req), .I_WRITE(wr),
      .I_NUM(num), .I_CH(ch), .I_WDATA(wdata), .O_BUSY(busy), .O_DONE(done), .O_OK(ok),
      .O_RDATA(rdata), .LNK(lnk));
   tra_checker tra_checker_i (.I_CLK(clk), .I_RESETN(rst_n),
      .control_byte(lnk.control_byte), .host_output_word(lnk.host_output_word),
      .channel(lnk.channel), .strobe(lnk.strobe), .status_byte(lnk.status_byte),
      .terminal_input_word(lnk.terminal_input_word), .answer_valid(lnk.answer_valid));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // nonvolatile store: survives restart, so it lives outside the design
   always @(posedge clk) begin
      if (nv_we === 1'b1) begin
         nv_cnt <= nv_cnt + 1;
         if (nv_num >= 6'h27 && nv_num <= 6'h2D)
            nv_img[nv_num - 6'h27][nv_ch] <= nv_data;
      end
   end
   task summarize();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         $display("MISMATCH at %0t got %h expected %h", $time, g, e);
         n_mismatch++;
      end
   endtask : chk
   // called at a falling edge; returns at the falling edge where done is high
   task xfer(input logic w, input logic [5:0] n, input logic [2:0] c, input logic [15:0] d);
      int k;
      logic [15:0] prev;
      prev = rdata;
      req = 1'b1;
      wr = w;
      num = n;
      ch = c;
      wdata = d;
      @(negedge clk);
      req = 1'b0;
      chk(16'(busy), 16'h0001);
      k = 0;
      while (done !== 1'b1 && k < 10) begin
         @(negedge clk);
         k++;
      end
      if (done !== 1'b1) begin
         n_mismatch++;
         summarize();
      end else begin
         chk(16'(ok), 16'h0001);
         chk(16'(busy), 16'h0000);
         chk(16'(lnk.status_byte), {8'h00, 2'b10, n});
         if (w) begin
            chk(lnk.terminal_input_word, 16'h0000);
            chk(rdata, prev);
         end
         got = rdata;
      end
   endtask : xfer
   // output word carries junk so a read that uses it shows up
   task rd(input logic [5:0] n, input logic [2:0] c, input logic [15:0] e);
      xfer(1'b0, n, c, 16'hA5A5);
      chk(got, e);
   endtask : rd
   task restart();
      rst_n = 1'b0;
      nv_valid = 1'b0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
   endtask : restart
   initial begin
      n_mismatch = 0;
      cmp_count = 0;
      nv_cnt = 0;
      req = 1'b0;
      wr = 1'b0;
      num = 6'h00;
      ch = 3'h0;
      wdata = 16'h0000;
      for (int s = 0; s < 7; s++)
         for (int c = 0; c < 8; c++)
            nv_img[s][c] = DEFS[s];
      restart();
      chk(act_conv, 16'h000A);
      chk(16'(unlocked), 16'h0000);
      for (int s = 0; s < 7; s++)
         rd(6'h27 + 6'(s), 3'h7, DEFS[s]);
      rd(tra_pkg::REG_FW_VERSION, 3'h0, tra_pkg::FW_VERSION);
      rd(6'h3F, 3'h1, 16'h0000);
      nv_valid = 1'b1;
      @(negedge clk);
      xfer(1'b1, tra_pkg::REG_NTC_B, 3'h2, 16'h1111);
      rd(tra_pkg::REG_NTC_B, 3'h2, tra_pkg::RST_NTC_B);
      chk(16'(nv_cnt), 16'h0000);
      xfer(1'b1, tra_pkg::REG_UNLOCK, 3'h0, tra_pkg::UNLOCK_VALUE);
      rd(tra_pkg::REG_UNLOCK, 3'h5, tra_pkg::UNLOCK_VALUE);
      chk(16'(unlocked), 16'h0001);
      xfer(1'b1, tra_pkg::REG_NTC_B, 3'h2, 16'h1111);
      xfer(1'b1, tra_pkg::REG_CONV_TIME, 3'h0, 16'h0014);
      xfer(1'b1, tra_pkg::REG_SENSOR_SEL, 3'h5, 16'h00FF);
      xfer(1'b1, 6'h3F, 3'h1, 16'h3333);
      rd(tra_pkg::REG_NTC_B, 3'h2, 16'h1111);
      rd(tra_pkg::REG_NTC_B, 3'h3, tra_pkg::RST_NTC_B);
      chk(act_conv, 16'h000A);
      chk(16'(ntc_act), 16'h0000);
      chk(16'(nv_cnt), 16'h0003);
      xfer(1'b1, tra_pkg::REG_UNLOCK, 3'h0, 16'h1234);
      chk(16'(unlocked), 16'h0000);
      xfer(1'b1, tra_pkg::REG_NTC_RNOM, 3'h2, 16'h2222);
      rd(tra_pkg::REG_NTC_RNOM, 3'h2, tra_pkg::RST_NTC_RNOM);
      restart();
      nv_valid = 1'b1;
      repeat (2) @(negedge clk);
      rd(tra_pkg::REG_UNLOCK, 3'h0, 16'h0000);
      rd(tra_pkg::REG_NTC_B, 3'h2, 16'h1111);
      chk(act_conv, 16'h0014);
      chk(16'(ntc_act), 16'h0020);
      summarize();
   end
endmodule : tb_top

/* tra_checker.sv */
`timescale 1ns/100ps
module tra_checker (
   // clock and reset
   input  wire logic        I_CLK,
   input  wire logic        I_RESETN,
   // link signals
   input  wire logic [7:0]  control_byte,
   input  wire logic [15:0] host_output_word,
   input  wire logic [2:0]  channel,
   input  wire logic        strobe,
   input  wire logic [7:0]  status_byte,
   input  wire logic [15:0] terminal_input_word,
   input  wire logic        answer_valid
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);
   reg_select_a: assert property (strobe |-> control_byte[7])
      else $error("strobe without register access bit");
   answer_time_a: assert property (strobe && control_byte[7] |=> answer_valid)
      else $error("answer missing one cycle after command");
   answer_cause_a: assert property (answer_valid |-> $past(strobe))
      else $error("answer without preceding command");
   one_outstanding_a: assert property (strobe |=> !strobe [*2])
      else $error("command issued while one is outstanding");
   read_echo_a: assert property (strobe && control_byte[7:6] == 2'b10
      |=> status_byte == $past(control_byte)) else $error("read status not echoed");
   write_ack_a: assert property (strobe && control_byte[7:6] == 2'b11
      |=> status_byte == ($past(control_byte) & 8'hBF)) else $error("write ack wrong");
   write_word_a: assert property (strobe && control_byte[7:6] == 2'b11
      |=> terminal_input_word == 16'h0000) else $error("write answer word not zero");
   fw_read_a: assert property (strobe && control_byte == 8'h89
      |=> terminal_input_word == tra_pkg::FW_VERSION) else $error("firmware word wrong");
   answer_hold_a: assert property (!answer_valid
      |-> $stable(status_byte) && $stable(terminal_input_word))
      else $error("answer changed without answer_valid");
endmodule : tra_checker

/* tra_if.sv */
`timescale 1ns/100ps
interface tra_if;
   logic       [7:0]  control_byte;
   logic       [15:0] host_output_word;
   logic       [2:0]  channel;
   logic              strobe;
   logic       [7:0]  status_byte;
   logic       [15:0] terminal_input_word;
   logic              answer_valid;
   modport terminal (
      input  control_byte, host_output_word, channel, strobe,
      output status_byte, terminal_input_word, answer_valid
   );
   modport master (
      output control_byte, host_output_word, channel, strobe,
      input  status_byte, terminal_input_word, answer_valid
   );
endinterface : tra_if

/* tra_master.sv */
`timescale 1ns/100ps
module tra_master (
   // clock and reset
   input  wire logic        I_CLK,
   input  wire logic        I_RESETN,
   // user request
   input  wire logic        I_REQ,
   input  wire logic        I_WRITE,
   input  wire logic [5:0]  I_NUM,
   input  wire logic [2:0]  I_CH,
   input  wire logic [15:0] I_WDATA,
   // user answer
   output logic             O_BUSY,
   output logic             O_DONE,
   output logic             O_OK,
   output logic [15:0]      O_RDATA,
   // process image link
   tra_if.master            LNK
);
   tra_pkg::tra_host_e state_q;
   logic [7:0]         ctrl_q;
   logic [15:0]        word_q;
   logic [2:0]         ch_q;
   logic               strobe_q;
   logic [7:0]         expect_st;

   always_comb begin
      expect_st = ctrl_q;
      expect_st[tra_pkg::CTRL_WR_BIT] = 1'b0;
   end

   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state_q  <= tra_pkg::ST_IDLE;
         ctrl_q   <= tra_pkg::ZERO_BYTE;
         word_q   <= tra_pkg::ZERO_WORD;
         ch_q     <= 3'h0;
         strobe_q <= 1'b0;
         O_BUSY   <= 1'b0;
         O_DONE   <= 1'b0;
         O_OK     <= 1'b0;
         O_RDATA  <= tra_pkg::ZERO_WORD;
      end else begin
         strobe_q <= 1'b0;
         O_DONE   <= 1'b0;
         case (state_q)
            tra_pkg::ST_IDLE: begin
               if (I_REQ) begin
                  ctrl_q   <= {1'b1, I_WRITE, I_NUM};
                  // passed through on reads too: the terminal must ignore it
                  word_q   <= I_WDATA;
                  ch_q     <= I_CH;
                  strobe_q <= 1'b1;
                  O_BUSY   <= 1'b1;
                  state_q  <= tra_pkg::ST_WAIT;
               end
            end
            tra_pkg::ST_WAIT: begin
               if (LNK.answer_valid) begin
                  O_OK   <= (LNK.status_byte == expect_st);
                  if (!ctrl_q[tra_pkg::CTRL_WR_BIT]) begin
                     O_RDATA <= LNK.terminal_input_word;
                  end
                  O_DONE  <= 1'b1;
                  O_BUSY  <= 1'b0;
                  state_q <= tra_pkg::ST_IDLE;
               end
            end
            default: state_q <= tra_pkg::ST_IDLE;
         endcase
      end
   end

   assign LNK.control_byte     = ctrl_q;
   assign LNK.host_output_word = word_q;
   assign LNK.channel          = ch_q;
   assign LNK.strobe           = strobe_q;
endmodule : tra_master

/* tra_pkg.sv */
package tra_pkg;
   // control and status byte layout
   localparam int          CTRL_REG_BIT    = 7;
   localparam int          CTRL_WR_BIT     = 6;
   localparam int          CTRL_NUM_MSB    = 5;
   localparam int          NUM_CHANNELS    = 8;
   localparam int          CH_W            = 3;
   // register numbers
   localparam logic [5:0]  REG_FW_VERSION  = 6'h09;
   localparam logic [5:0]  REG_UNLOCK      = 6'h1F;
   localparam logic [5:0]  REG_SENSOR_SEL  = 6'h27;
   localparam logic [5:0]  REG_CONV_TIME   = 6'h28;
   localparam logic [5:0]  REG_NTC_B       = 6'h29;
   localparam logic [5:0]  REG_NTC_RNOM    = 6'h2A;
   localparam logic [5:0]  REG_NTC_TREF    = 6'h2B;
   localparam logic [5:0]  REG_NTC_LOW     = 6'h2C;
   localparam logic [5:0]  REG_NTC_HIGH    = 6'h2D;
   // values and defaults
   localparam logic [15:0] UNLOCK_VALUE    = 16'h1235;
   localparam logic [15:0] RST_UNLOCK      = 16'h0000;
   localparam logic [15:0] RST_SENSOR_SEL  = 16'h0000;
   localparam logic [15:0] RST_CONV_TIME   = 16'h000A;
   localparam logic [15:0] RST_NTC_B       = 16'h0F78;
   localparam logic [15:0] RST_NTC_RNOM    = 16'h03E8;
   localparam logic [15:0] RST_NTC_TREF    = 16'h0019;
   localparam logic [15:0] RST_NTC_LOW     = 16'hFFD8;
   localparam logic [15:0] RST_NTC_HIGH    = 16'h0082;
   localparam logic [7:0]  SENSOR_USER_NTC = 8'hFF;
   localparam logic [15:0] ZERO_WORD       = 16'h0000;
   localparam logic [7:0]  ZERO_BYTE       = 8'h00;
   // firmware version text, arbitrary value
   localparam logic [15:0] FW_VERSION      = 16'h3130;
   // register slot indices
   localparam int          NUM_SLOTS       = 7;
   localparam int          SLOT_SENSOR     = 0;
   localparam int          SLOT_CONV       = 1;
   localparam int          SLOT_B          = 2;
   localparam int          SLOT_RNOM       = 3;
   localparam int          SLOT_TREF       = 4;
   localparam int          SLOT_LOW        = 5;
   localparam int          SLOT_HIGH       = 6;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DONE = 2'b10
   } tra_host_e;
endpackage : tra_pkg

/* tra_terminal.sv */
`timescale 1ns/100ps
module tra_terminal (
   // clock and reset
   input  wire logic        I_CLK,
   input  wire logic        I_RESETN,
   // process image link
   tra_if.terminal          LNK,
   // nonvolatile store, loaded at power-up
   input  wire logic [15:0] I_NV_SENSOR   [tra_pkg::NUM_CHANNELS],
   input  wire logic [15:0] I_NV_CONV,
   input  wire logic [15:0] I_NV_B        [tra_pkg::NUM_CHANNELS],
   input  wire logic [15:0] I_NV_RNOM     [tra_pkg::NUM_CHANNELS],
   input  wire logic [15:0] I_NV_TREF     [tra_pkg::NUM_CHANNELS],
   input  wire logic [15:0] I_NV_LOW      [tra_pkg::NUM_CHANNELS],
   input  wire logic [15:0] I_NV_HIGH     [tra_pkg::NUM_CHANNELS],
   input  wire logic        I_NV_VALID,
   // nonvolatile write port
   output logic             O_NV_WE,
   output logic [2:0]       O_NV_CH,
   output logic [5:0]       O_NV_NUM,
   output logic [15:0]      O_NV_DATA,
   // active settings for the measurement path
   output logic [15:0]      O_ACT_CONV,
   output logic [7:0]       O_USER_NTC_ACTIVE,
   output logic             O_UNLOCKED
);
   localparam int NC = tra_pkg::NUM_CHANNELS;
   localparam int NS = tra_pkg::NUM_SLOTS;

   logic [15:0] regs_q [NC][NS];
   logic [15:0] unlock_q;
   logic        loaded_q;
   logic [7:0]  status_q;
   logic [15:0] in_word_q;
   logic        valid_q;

   logic        is_reg;
   logic        is_wr;
   logic [5:0]  num;
   logic [2:0]  ch;
   int          slot;
   logic        unlocked;

   assign is_reg   = LNK.strobe & LNK.control_byte[tra_pkg::CTRL_REG_BIT];
   assign is_wr    = LNK.control_byte[tra_pkg::CTRL_WR_BIT];
   assign num      = LNK.control_byte[tra_pkg::CTRL_NUM_MSB:0];
   assign ch       = LNK.channel;
   assign unlocked = (unlock_q == tra_pkg::UNLOCK_VALUE);

   always_comb begin
      case (num)
         tra_pkg::REG_SENSOR_SEL: slot = tra_pkg::SLOT_SENSOR;
         tra_pkg::REG_CONV_TIME:  slot = tra_pkg::SLOT_CONV;
         tra_pkg::REG_NTC_B:      slot = tra_pkg::SLOT_B;
         tra_pkg::REG_NTC_RNOM:   slot = tra_pkg::SLOT_RNOM;
         tra_pkg::REG_NTC_TREF:   slot = tra_pkg::SLOT_TREF;
         tra_pkg::REG_NTC_LOW:    slot = tra_pkg::SLOT_LOW;
         tra_pkg::REG_NTC_HIGH:   slot = tra_pkg::SLOT_HIGH;
         default:                 slot = NS;
      endcase
   end

   // restart drops the code word, so protection is back after power-up
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         unlock_q <= tra_pkg::RST_UNLOCK;
      end else if (is_reg && is_wr && num == tra_pkg::REG_UNLOCK) begin
         unlock_q <= LNK.host_output_word;
      end
   end

   // working copies: defaults at reset, nonvolatile image once, then writes
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         loaded_q <= 1'b0;
         for (int c = 0; c < NC; c++) begin
            regs_q[c][tra_pkg::SLOT_SENSOR] <= tra_pkg::RST_SENSOR_SEL;
            regs_q[c][tra_pkg::SLOT_CONV]   <= tra_pkg::RST_CONV_TIME;
            regs_q[c][tra_pkg::SLOT_B]      <= tra_pkg::RST_NTC_B;
            regs_q[c][tra_pkg::SLOT_RNOM]   <= tra_pkg::RST_NTC_RNOM;
            regs_q[c][tra_pkg::SLOT_TREF]   <= tra_pkg::RST_NTC_TREF;
            regs_q[c][tra_pkg::SLOT_LOW]    <= tra_pkg::RST_NTC_LOW;
            regs_q[c][tra_pkg::SLOT_HIGH]   <= tra_pkg::RST_NTC_HIGH;
         end
      end else if (!loaded_q) begin
         if (I_NV_VALID) begin
            loaded_q <= 1'b1;
            for (int c = 0; c < NC; c++) begin
               regs_q[c][tra_pkg::SLOT_SENSOR] <= I_NV_SENSOR[c];
               regs_q[c][tra_pkg::SLOT_CONV]   <= I_NV_CONV;
               regs_q[c][tra_pkg::SLOT_B]      <= I_NV_B[c];
               regs_q[c][tra_pkg::SLOT_RNOM]   <= I_NV_RNOM[c];
               regs_q[c][tra_pkg::SLOT_TREF]   <= I_NV_TREF[c];
               regs_q[c][tra_pkg::SLOT_LOW]    <= I_NV_LOW[c];
               regs_q[c][tra_pkg::SLOT_HIGH]   <= I_NV_HIGH[c];
            end
         end
      end else if (is_reg && is_wr && unlocked && slot < NS) begin
         regs_q[ch][slot] <= LNK.host_output_word;
      end
   end

   // nonvolatile write mirrors every accepted user write to a settings register; code word writes to REG_UNLOCK are not mirrored
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_NV_WE   <= 1'b0;
         O_NV_CH   <= 3'h0;
         O_NV_NUM  <= 6'h00;
         O_NV_DATA <= tra_pkg::ZERO_WORD;
      end else begin
         O_NV_WE   <= loaded_q && is_reg && is_wr && unlocked && slot < NS;
         O_NV_CH   <= ch;
         O_NV_NUM  <= num;
         O_NV_DATA <= LNK.host_output_word;
      end
   end

   // answer: one cycle after the strobe
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         status_q  <= tra_pkg::ZERO_BYTE;
         in_word_q <= tra_pkg::ZERO_WORD;
         valid_q   <= 1'b0;
      end else begin
         valid_q <= is_reg;
         if (is_reg) begin
            status_q <= LNK.control_byte;
            if (is_wr) begin
               status_q[tra_pkg::CTRL_WR_BIT] <= 1'b0;
               in_word_q <= tra_pkg::ZERO_WORD;
            end else if (num == tra_pkg::REG_FW_VERSION) begin
               in_word_q <= tra_pkg::FW_VERSION;
            end else if (num == tra_pkg::REG_UNLOCK) begin
               in_word_q <= unlock_q;
            end else if (slot < NS) begin
               in_word_q <= regs_q[ch][slot];
            end else begin
               in_word_q <= tra_pkg::ZERO_WORD;
            end
         end
      end
   end

   assign LNK.status_byte         = status_q;
   assign LNK.terminal_input_word = in_word_q;
   assign LNK.answer_valid        = valid_q;

   // operating settings are frozen at load time and follow writes only after restart
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_ACT_CONV        <= tra_pkg::RST_CONV_TIME;
         O_USER_NTC_ACTIVE <= 8'h00;
         O_UNLOCKED        <= 1'b0;
      end else begin
         O_UNLOCKED <= unlocked;
         if (I_NV_VALID && !loaded_q) begin
            O_ACT_CONV <= I_NV_CONV;
            for (int c = 0; c < NC; c++) begin
               O_USER_NTC_ACTIVE[c] <= (I_NV_SENSOR[c][7:0] == tra_pkg::SENSOR_USER_NTC)
                                       && (I_NV_SENSOR[c][15:8] == tra_pkg::ZERO_BYTE);
            end
         end
      end
   end
endmodule : tra_terminal
